// ==== psc_gate_strap.sv ====
// The implementer's own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "psc_cfg.svh"
// How it works
// - either enable low tristates both PWM outputs
// - tristate gating has no disabling control
// - enable raises driver enable after short delay
// - hold driver enable through ramp-down, then delay
// - sample pins at power-up and restore
// - each pin classed low, open, high, resistor
// - one pin three settings, two pins nine
// - resistor mode gives 31 codes per pin
// - bus address only from address straps
// - ceiling fixed at 110% of pin voltage
// - strapped values readable by bus, only vout overwritable
// - host can save the vout setting to NVM
module psc_gate_strap (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic hardware_enable_in,
  input wire logic ramp_done_in,
  input wire logic pwm_high_in,
  input wire logic pwm_low_in,
  input wire logic [1:0] bus_addr_strap_0_conn,
  input wire logic [4:0] bus_addr_strap_0_code,
  input wire logic [1:0] bus_addr_strap_1_conn,
  input wire logic [4:0] bus_addr_strap_1_code,
  input wire logic [1:0] vout_select_pin_0_conn,
  input wire logic [4:0] vout_select_pin_0_code,
  input wire logic [1:0] vout_select_pin_1_conn,
  input wire logic [4:0] vout_select_pin_1_code,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [15:0] reg_rdata,
  output logic high_side_pwm_out,
  output logic high_side_pwm_oe,
  output logic low_side_pwm_out,
  output logic low_side_pwm_oe,
  output logic driver_enable_out,
  output logic [6:0] bus_target_addr,
  output logic [9:0] output_voltage_ceiling,
  output logic [9:0] vout_setting
);

  // raw pin classes: conn in [6:5], code in [4:0]; index 0..3 = sa0, sa1, v0, v1
  logic [6:0] pin_raw [4];
  logic [6:0] pin_s1_reg [4];
  logic [6:0] pin_s2_reg [4];
  logic en_s1_reg; // first stage, read only by the second
  logic en_s2_reg;

  assign pin_raw[0] = {bus_addr_strap_0_conn, bus_addr_strap_0_code};
  assign pin_raw[1] = {bus_addr_strap_1_conn, bus_addr_strap_1_code};
  assign pin_raw[2] = {vout_select_pin_0_conn, vout_select_pin_0_code};
  assign pin_raw[3] = {vout_select_pin_1_conn, vout_select_pin_1_code};

  // two-stage synchronisers for every pin class, they come from analog timing
  for (genvar i = 0; i < 4; i++) begin : g_pin_sync
    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
        pin_s1_reg[i] <= 7'h00;
        pin_s2_reg[i] <= 7'h00;
      end else begin
        pin_s1_reg[i] <= pin_raw[i];
        pin_s2_reg[i] <= pin_s1_reg[i];
      end
    end
  end

  // enable pin synchroniser
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      en_s1_reg <= 1'b0;
      en_s2_reg <= 1'b0;
    end else begin
      en_s1_reg <= hardware_enable_in;
      en_s2_reg <= en_s1_reg;
    end
  end

  // strap table: index = v1 * 3 + v0, value in 10 mV units
  function automatic logic [9:0] strap_vout(input logic [3:0] idx);
    case (idx)
      4'h0: strap_vout = 10'h03C;
      4'h1: strap_vout = 10'h050;
      4'h2: strap_vout = 10'h064;
      4'h3: strap_vout = 10'h078;
      4'h4: strap_vout = 10'h096;
      4'h5: strap_vout = 10'h0B4;
      4'h6: strap_vout = 10'h0FA;
      4'h7: strap_vout = 10'h14A;
      default: strap_vout = 10'h168;
    endcase
  endfunction : strap_vout

  // single-resistor table, code 0..30 in 10 mV units
  function automatic logic [9:0] single_res_vout(input logic [4:0] c);
    case (c)
      5'h0F: single_res_vout = 10'h08C;
      5'h10: single_res_vout = 10'h096;
      5'h11: single_res_vout = 10'h0A0;
      5'h12: single_res_vout = 10'h0AA;
      5'h13: single_res_vout = 10'h0B4;
      5'h14: single_res_vout = 10'h0BE;
      5'h15: single_res_vout = 10'h0C8;
      5'h16: single_res_vout = 10'h0D2;
      5'h17: single_res_vout = 10'h0DC;
      5'h18: single_res_vout = 10'h0E6;
      5'h19: single_res_vout = 10'h0FA;
      5'h1A: single_res_vout = 10'h12C;
      5'h1B: single_res_vout = 10'h14A;
      5'h1C: single_res_vout = 10'h190;
      5'h1D: single_res_vout = 10'h1F4;
      5'h1E: single_res_vout = 10'h226;
      // first fifteen codes step 50 mV from 0.60 V; code 31 is out of range
      default: single_res_vout = (c < 5'h0F) ? 10'(10'h03C + 10'(c) * 10'h005) : 10'h226;
    endcase
  endfunction : single_res_vout

  // combinational decode of the synchronised pin classes
  logic [1:0] conn [4];
  logic [4:0] code [4];
  logic [1:0] lvl [4];
  logic [9:0] dec_vout;
  logic [6:0] dec_addr;

  for (genvar i = 0; i < 4; i++) begin : g_pin_split
    assign conn[i] = pin_s2_reg[i][6:5];
    assign code[i] = pin_s2_reg[i][4:0];
    // strap level 0/1/2 for low/open/high
    assign lvl[i] = (conn[i] == psc_pkg::CONN_RES) ? 2'h0 : conn[i];
  end

  always_comb begin
    // voltage: two resistors, single resistor, or three-level straps
    if (conn[2] == psc_pkg::CONN_RES && conn[3] == psc_pkg::CONN_RES) begin
      dec_vout = 10'(code[2]) + 10'(code[3]) * 10'h019;
    end else if (conn[3] == psc_pkg::CONN_RES) begin
      dec_vout = single_res_vout(code[3]);
    end else begin
      // widen before the product, a two-bit product would drop the high strap row
      dec_vout = strap_vout(4'(lvl[3]) * 4'h3 + 4'(lvl[2]));
    end
    // address comes only from the straps, nothing on the bus touches it
    if (conn[0] == psc_pkg::CONN_RES) begin
      dec_addr = 7'(`PSC_ADDR_BASE + 7'(code[0]));
    end else begin
      dec_addr = 7'(`PSC_ADDR_BASE + 7'(lvl[1]) * 7'h03 + 7'(lvl[0]));
    end
  end

  // configuration store and command state
  logic [1:0] boot_reg, boot_next;
  logic ctrl_reg, ctrl_next;
  logic [9:0] vout_reg, vout_next;
  logic [9:0] ceil_reg, ceil_next;
  logic [6:0] addr_reg, addr_next;
  logic [9:0] nvm_reg, nvm_next; // single stored word stands in for the NVM image
  logic nvm_ok_reg, nvm_ok_next;
  logic sample;
  logic wr_cmd;

  assign wr_cmd = reg_write && reg_addr == `PSC_OFS_CMD;
  // power-up sample once the synchronisers are full, or on restore
  assign sample = (boot_reg == `PSC_BOOT_CYC) || (wr_cmd && reg_wdata == `PSC_CMD_RESTORE);

  always_comb begin
    boot_next = (boot_reg == 2'h3) ? boot_reg : 2'(boot_reg + 2'h1);
    ctrl_next = ctrl_reg;
    vout_next = vout_reg;
    ceil_next = ceil_reg;
    addr_next = addr_reg;
    nvm_next = nvm_reg;
    nvm_ok_next = nvm_ok_reg;
    if (reg_write && reg_addr == `PSC_OFS_CTRL) begin
      ctrl_next = reg_wdata[`PSC_CTRL_OPEN_BIT];
    end
    if (reg_write && reg_addr == `PSC_OFS_VOUT) begin
      vout_next = reg_wdata[9:0];
    end
    if (wr_cmd && reg_wdata == `PSC_CMD_SAVE) begin
      nvm_next = vout_reg;
      nvm_ok_next = 1'b1;
    end
    // sampling wins over a same-cycle bus write; stored word if both vout pins are open and a word is saved, pins otherwise
    if (sample) begin
      vout_next = (conn[2] == psc_pkg::CONN_OPEN && conn[3] == psc_pkg::CONN_OPEN && nvm_ok_reg) ?
                  nvm_reg : dec_vout;
      ceil_next = 10'(dec_vout + dec_vout / 10'h00A);
      addr_next = dec_addr;
    end
  end

  // register the configuration; the ceiling and address have no write path
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      boot_reg <= 2'h0;
      ctrl_reg <= `PSC_CTRL_RST;
      vout_reg <= `PSC_VOUT_RST;
      ceil_reg <= 10'h000;
      addr_reg <= 7'h00;
      nvm_reg <= 10'h000;
      nvm_ok_reg <= 1'b0;
    end else begin
      boot_reg <= boot_next;
      ctrl_reg <= ctrl_next;
      vout_reg <= vout_next;
      ceil_reg <= ceil_next;
      addr_reg <= addr_next;
      nvm_reg <= nvm_next;
      nvm_ok_reg <= nvm_ok_next;
    end
  end

  // driver-enable sequencer
  psc_pkg::psc_drv_state_type st_reg, st_next;
  logic [7:0] cnt_reg, cnt_next;
  logic run;
  logic drv_next;
  logic oe_next;

  // both enables must be high to run
  assign run = en_s2_reg && ctrl_reg;

  always_comb begin
    st_next = st_reg;
    cnt_next = 8'h00;
    unique case (st_reg)
      psc_pkg::DRV_OFF: begin
        if (run) begin
          st_next = psc_pkg::DRV_DLY_ON;
        end
      end
      psc_pkg::DRV_DLY_ON: begin
        cnt_next = 8'(cnt_reg + 8'h01);
        if (!run) begin
          st_next = psc_pkg::DRV_OFF; // driver never rose, nothing to ramp
        end else if (cnt_reg == 8'(`PSC_TD_ED_CYC - 1)) begin
          st_next = psc_pkg::DRV_ON;
        end
      end
      psc_pkg::DRV_ON: begin
        if (!run) begin
          st_next = psc_pkg::DRV_RAMP;
        end
      end
      psc_pkg::DRV_RAMP: begin
        // driver held high while the output ramps down
        if (run) begin
          st_next = psc_pkg::DRV_ON;
        end else if (ramp_done_in) begin
          st_next = psc_pkg::DRV_DLY_OFF;
        end
      end
      psc_pkg::DRV_DLY_OFF: begin
        cnt_next = 8'(cnt_reg + 8'h01);
        if (run) begin
          st_next = psc_pkg::DRV_ON;
        end else if (cnt_reg == 8'(`PSC_TD_OFF_CYC - 1)) begin
          st_next = psc_pkg::DRV_OFF;
        end
      end
      default: st_next = psc_pkg::DRV_OFF; // illegal code recovers
    endcase
    drv_next = (st_next == psc_pkg::DRV_ON) || (st_next == psc_pkg::DRV_RAMP) ||
               (st_next == psc_pkg::DRV_DLY_OFF);
    // gating follows the enables alone, no bit can override it
    oe_next = run;
  end

  // register state, driver enable and gated PWM
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= psc_pkg::DRV_OFF;
      cnt_reg <= 8'h00;
      driver_enable_out <= 1'b0;
      high_side_pwm_oe <= 1'b0;
      low_side_pwm_oe <= 1'b0;
      high_side_pwm_out <= 1'b0;
      low_side_pwm_out <= 1'b0;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      driver_enable_out <= drv_next;
      high_side_pwm_oe <= oe_next;
      low_side_pwm_oe <= oe_next;
      high_side_pwm_out <= pwm_high_in && oe_next;
      low_side_pwm_out <= pwm_low_in && oe_next;
    end
  end

  // read port: data one cycle after the strobe, unmapped reads zero
  logic [15:0] rdata_next;

  always_comb begin
    rdata_next = 16'h0000;
    if (reg_read) begin
      unique case (reg_addr)
        `PSC_OFS_CTRL: rdata_next = {15'h0000, ctrl_reg};
        `PSC_OFS_VOUT: rdata_next = {6'h00, vout_reg};
        `PSC_OFS_CEIL: rdata_next = {6'h00, ceil_reg};
        `PSC_OFS_ADDR: rdata_next = {9'h000, addr_reg};
        `PSC_OFS_STAT: rdata_next = {8'h00, nvm_ok_reg, en_s2_reg, driver_enable_out, st_reg};
        `PSC_OFS_PINS: rdata_next = {8'h00, conn[3], conn[2], conn[1], conn[0]};
        `PSC_OFS_NVM: rdata_next = {6'h00, nvm_reg};
        default: rdata_next = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= rdata_next;
    end
  end

  assign bus_target_addr = addr_reg;
  assign output_voltage_ceiling = ceil_reg;
  assign vout_setting = vout_reg;

endmodule : psc_gate_strap

// ==== psc_cfg.svh ====
`ifndef PSC_CFG_SVH
`define PSC_CFG_SVH
// register offsets (byte addresses on the plain port)
`define PSC_OFS_CTRL 8'h00
`define PSC_OFS_CMD 8'h04
`define PSC_OFS_VOUT 8'h08
`define PSC_OFS_CEIL 8'h0C
`define PSC_OFS_ADDR 8'h10
`define PSC_OFS_STAT 8'h14
`define PSC_OFS_PINS 8'h18
`define PSC_OFS_NVM 8'h1C
// command codes written to the command register
`define PSC_CMD_RESTORE 16'h0001
`define PSC_CMD_SAVE 16'h0002
// field positions
`define PSC_CTRL_OPEN_BIT 0
// reset values
`define PSC_CTRL_RST 1'b0
`define PSC_VOUT_RST 10'h03C
// base of the bus target address, arbitrary value
`define PSC_ADDR_BASE 7'h20
// timing: period and delays in ns, cycles rounded up
`define PSC_CLK_NS 25
`define PSC_TD_ED_NS 500
`define PSC_TD_OFF_NS 1000
`define PSC_TD_ED_CYC ((`PSC_TD_ED_NS + `PSC_CLK_NS - 1) / `PSC_CLK_NS)
`define PSC_TD_OFF_CYC ((`PSC_TD_OFF_NS + `PSC_CLK_NS - 1) / `PSC_CLK_NS)
// boot cycles before the first pin sample (two sync stages settle)
`define PSC_BOOT_CYC 2'h2
`endif

// ==== psc_pkg.sv ====
package psc_pkg;
  // driver-enable sequencing states, one-hot
  typedef enum logic [4:0] {
    DRV_OFF = 5'h01,
    DRV_DLY_ON = 5'h02,
    DRV_ON = 5'h04,
    DRV_RAMP = 5'h08,
    DRV_DLY_OFF = 5'h10
  } psc_drv_state_type;
  // connection class reported by the pin front end
  typedef enum logic [1:0] {
    CONN_LOW = 2'h0,
    CONN_OPEN = 2'h1,
    CONN_HIGH = 2'h2,
    CONN_RES = 2'h3
  } psc_conn_type;
endpackage : psc_pkg

// ==== psc_gate_strap_chk.sv ====
`timescale 1ns/1ps
`include "psc_cfg.svh"
module psc_gate_strap_chk (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic hardware_enable_in,
  input wire logic ramp_done_in,
  input wire logic pwm_high_in,
  input wire logic pwm_low_in,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [15:0] reg_rdata,
  input wire logic high_side_pwm_out,
  input wire logic high_side_pwm_oe,
  input wire logic low_side_pwm_out,
  input wire logic low_side_pwm_oe,
  input wire logic driver_enable_out,
  input wire logic [6:0] bus_target_addr,
  input wire logic [9:0] output_voltage_ceiling
);
  // saturating ages so long runs never wrap back into a match
  logic [7:0] on_reg, on_next, done_reg, done_next, age_reg, age_next;
  logic restore;
  assign restore = reg_write && reg_addr == `PSC_OFS_CMD && reg_wdata == `PSC_CMD_RESTORE;
  // next ages: pins driven, ramp done held, cycles since last sampling
  always_comb begin
    on_next = high_side_pwm_oe ? on_reg + {7'h00, on_reg != 8'hFF} : 8'h00;
    done_next = ramp_done_in ? done_reg + {7'h00, done_reg != 8'hFF} : 8'h00;
    age_next = restore ? 8'h00 : age_reg + {7'h00, age_reg != 8'hFF};
  end
  // age registers, cleared by reset since reset is also a sampling event
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      on_reg <= 8'h00;
      done_reg <= 8'h00;
      age_reg <= 8'h00;
    end else begin
      on_reg <= on_next;
      done_reg <= done_next;
      age_reg <= age_next;
    end
  end
  default clocking dc @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_vout_wr; reg_write && reg_addr == `PSC_OFS_VOUT; endsequence
  sequence s_vout_rd; reg_read && reg_addr == `PSC_OFS_VOUT; endsequence
  a_hiz_hw_off: assert property (!hardware_enable_in [*4] |-> !high_side_pwm_oe && !low_side_pwm_oe)
    else $error("pwm pins driven with hardware enable low");
  a_hiz_bus_off: assert property (reg_write && reg_addr == `PSC_OFS_CTRL && !reg_wdata[0] |->
    ##2 !high_side_pwm_oe && !low_side_pwm_oe) else $error("pwm pins driven after bus disable");
  a_pwm_gated: assert property (high_side_pwm_out == (high_side_pwm_oe && $past(pwm_high_in)) &&
    low_side_pwm_out == (low_side_pwm_oe && $past(pwm_low_in))) else $error("pwm level not the gated input");
  a_drv_rise_delay: assert property ($rose(driver_enable_out) |-> on_reg == `PSC_TD_ED_CYC)
    else $error("driver enable rose at wrong delay");
  a_drv_fall_delay: assert property ($fell(driver_enable_out) |-> done_reg >= 8'h28 && done_reg <= 8'h2A)
    else $error("driver enable fell off the turn-off delay");
  a_addr_fixed: assert property ($changed(bus_target_addr) |-> age_reg <= 8'h06)
    else $error("bus address moved without sampling");
  a_ceil_fixed: assert property ($changed(output_voltage_ceiling) |-> age_reg <= 8'h06)
    else $error("voltage ceiling moved without sampling");
  a_vout_readback: assert property (s_vout_wr ##2 s_vout_rd |=> reg_rdata[9:0] == $past(reg_wdata[9:0], 3))
    else $error("vout read back differs from write");
endmodule : psc_gate_strap_chk
bind psc_gate_strap psc_gate_strap_chk chk_u (.core_clk(core_clk), .rst_n(rst_n),
  .hardware_enable_in(hardware_enable_in), .ramp_done_in(ramp_done_in), .pwm_high_in(pwm_high_in),
  .pwm_low_in(pwm_low_in), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
  .reg_read(reg_read), .reg_rdata(reg_rdata), .high_side_pwm_out(high_side_pwm_out),
  .high_side_pwm_oe(high_side_pwm_oe), .low_side_pwm_out(low_side_pwm_out), .low_side_pwm_oe(low_side_pwm_oe),
  .driver_enable_out(driver_enable_out), .bus_target_addr(bus_target_addr),
  .output_voltage_ceiling(output_voltage_ceiling));

// ==== psc_power_stage.sv ====
`timescale 1ns/1ps
// power stage stand-in: reports ramp-down done a while after switching stops
module psc_power_stage #(
  parameter int RAMP_CYC = 6
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic high_side_pwm_oe,
  input wire logic low_side_pwm_oe,
  input wire logic driver_enable_out,
  output logic ramp_done_in
);
  logic [7:0] fall_reg, fall_next; // cycles enabled with both gates floating
  // done stays up until the driver is released, since the sequencer waits on it
  always_comb begin
    fall_next = 8'h00;
    if (driver_enable_out && !high_side_pwm_oe && !low_side_pwm_oe) begin
      fall_next = fall_reg + {7'h00, fall_reg != 8'hFF};
    end
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fall_reg <= 8'h00;
    end else begin
      fall_reg <= fall_next;
    end
  end
  assign ramp_done_in = fall_reg >= 8'(RAMP_CYC);
endmodule : psc_power_stage

// ==== psc_gate_strap_tb_top.sv ====
`timescale 1ns/1ps
`include "psc_cfg.svh"
module psc_gate_strap_tb_top;
  logic core_clk, rst_n, hw_en, ramp_done, pwm_hi, pwm_lo, reg_write, reg_read;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic [1:0] pin_conn [4]; // addr 0, addr 1, vout 0, vout 1
  logic [4:0] pin_code [4];
  logic hs_out, hs_oe, ls_out, ls_oe, drv_en;
  logic [6:0] tgt_addr;
  logic [9:0] ceil_v, vout;
  int errors, checked;
  // strap vout in 10 mV units, index vout1 * 3 + vout0
  logic [15:0] vtab [9] = '{16'h003C, 16'h0050, 16'h0064, 16'h0078, 16'h0096, 16'h00B4, 16'h00FA, 16'h014A, 16'h0168};
  logic [4:0] rcode [3] = '{5'h00, 5'h0F, 5'h1E}; // ends of the single-resistor steps
  logic [15:0] rvolt [3] = '{16'h003C, 16'h008C, 16'h0226};
  psc_gate_strap dut_u (.core_clk(core_clk), .rst_n(rst_n), .hardware_enable_in(hw_en),
    .ramp_done_in(ramp_done), .pwm_high_in(pwm_hi), .pwm_low_in(pwm_lo),
    .bus_addr_strap_0_conn(pin_conn[0]), .bus_addr_strap_0_code(pin_code[0]),
    .bus_addr_strap_1_conn(pin_conn[1]), .bus_addr_strap_1_code(pin_code[1]),
    .vout_select_pin_0_conn(pin_conn[2]), .vout_select_pin_0_code(pin_code[2]),
    .vout_select_pin_1_conn(pin_conn[3]), .vout_select_pin_1_code(pin_code[3]),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .high_side_pwm_out(hs_out), .high_side_pwm_oe(hs_oe), .low_side_pwm_out(ls_out),
    .low_side_pwm_oe(ls_oe), .driver_enable_out(drv_en), .bus_target_addr(tgt_addr),
    .output_voltage_ceiling(ceil_v), .vout_setting(vout));
  psc_power_stage stage_u (.core_clk(core_clk), .rst_n(rst_n), .high_side_pwm_oe(hs_oe),
    .low_side_pwm_oe(ls_oe), .driver_enable_out(drv_en), .ramp_done_in(ramp_done));
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // modulator stand-in: two different toggling patterns
  always @(posedge core_clk) begin
    pwm_hi <= ~pwm_hi;
    pwm_lo <= pwm_hi;
  end
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // every access starts after a rising edge; the strobe drops after its edge
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge core_clk);
    reg_write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [15:0] exp, input string name);
    @(posedge core_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge core_clk);
    reg_read <= 1'b0;
    @(negedge core_clk);
    check(name, reg_rdata, exp);
  endtask : rd
  // new pin connections, let the synchronisers settle, then resample
  task automatic load(input logic [7:0] conns, input logic [19:0] codes);
    @(posedge core_clk);
    for (int i = 0; i < 4; i++) begin
      pin_conn[i] <= conns[2*i +: 2];
      pin_code[i] <= codes[5*i +: 5];
    end
    repeat (4) @(posedge core_clk);
    wr(`PSC_OFS_CMD, `PSC_CMD_RESTORE);
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
  endtask : load
  task automatic wait_drv(input logic v);
    int n;
    n = 0;
    while (drv_en !== v && n < 200) begin
      @(negedge core_clk);
      n++;
    end
    check("driver enable", {15'h0000, drv_en}, {15'h0000, v});
  endtask : wait_drv
  task automatic final_report;
    if (errors == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report
  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    final_report();
  end
  initial begin
    errors = 0;
    checked = 0;
    rst_n = 1'b0;
    hw_en = 1'b0;
    pwm_hi = 1'b0;
    pwm_lo = 1'b0;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    pin_conn = '{2'h2, 2'h1, 2'h1, 2'h2}; // power-up straps
    pin_code = '{5'h00, 5'h00, 5'h00, 5'h00};
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (8) @(negedge core_clk);
    check("ceiling", {6'h00, ceil_v}, 16'h016B);
    check("address", {9'h000, tgt_addr}, 16'h0025);
    check("vout", {6'h00, vout}, 16'h014A);
    rd(`PSC_OFS_PINS, 16'h0096, "pins");
    rd(`PSC_OFS_STAT, 16'h0001, "status idle");
    wr(`PSC_OFS_CEIL, 16'h03FF);
    wr(`PSC_OFS_ADDR, 16'h007F);
    rd(`PSC_OFS_CEIL, 16'h016B, "ceiling reg");
    rd(`PSC_OFS_ADDR, 16'h0025, "address reg");
    rd(8'h20, 16'h0000, "unmapped");
    wr(`PSC_OFS_VOUT, 16'h0123);
    rd(`PSC_OFS_VOUT, 16'h0123, "vout reg");
    for (int i = 0; i < 9; i++) begin
      load({2'(i / 3), 2'(i % 3), 4'h0}, 20'h00000);
      check("strap vout", {6'h00, vout}, vtab[i]);
      check("strap ceiling", {6'h00, ceil_v}, vtab[i] + vtab[i] / 16'h000A);
    end
    rd(`PSC_OFS_PINS, 16'h00A0, "pins");
    check("address", {9'h000, tgt_addr}, 16'h0020);
    // pin moves alone must not disturb the stored settings
    @(posedge core_clk);
    pin_conn[3] <= 2'h0;
    repeat (8) @(negedge core_clk);
    check("held ceiling", {6'h00, ceil_v}, 16'h018C);
    load(8'hF3, {5'h05, 5'h08, 5'h00, 5'h1E});
    check("res vout", {6'h00, vout}, 16'h0085);
    check("res ceiling", {6'h00, ceil_v}, 16'h0092);
    check("res address", {9'h000, tgt_addr}, 16'h003E);
    for (int j = 0; j < 3; j++) begin
      load(8'hC6, {rcode[j], 15'h0000});
      check("single vout", {6'h00, vout}, rvolt[j]);
      check("single ceiling", {6'h00, ceil_v}, rvolt[j] + rvolt[j] / 16'h000A);
    end
    wr(`PSC_OFS_VOUT, 16'h00AB);
    wr(`PSC_OFS_CMD, `PSC_CMD_SAVE);
    rd(`PSC_OFS_NVM, 16'h00AB, "stored word");
    load(8'h50, 20'h00000);
    check("stored vout", {6'h00, vout}, 16'h00AB);
    check("pin ceiling", {6'h00, ceil_v}, 16'h00A5);
    @(posedge core_clk);
    hw_en <= 1'b1;
    wr(`PSC_OFS_CTRL, 16'h0001);
    wait_drv(1'b1);
    check("pins driven", {14'h0000, hs_oe, ls_oe}, 16'h0003);
    // outputs carry the modulator levels of the previous edge
    check("pwm follow", {14'h0000, hs_out, ls_out}, {14'h0000, ~pwm_hi, pwm_hi});
    @(posedge core_clk);
    hw_en <= 1'b0;
    repeat (5) @(negedge core_clk);
    check("pins float", {14'h0000, hs_oe, ls_oe}, 16'h0000);
    check("pwm held low", {14'h0000, hs_out, ls_out}, 16'h0000);
    check("driver held", {15'h0000, drv_en}, 16'h0001);
    wait_drv(1'b0);
    @(posedge core_clk);
    hw_en <= 1'b1;
    wait_drv(1'b1);
    wr(`PSC_OFS_CTRL, 16'h0000);
    repeat (3) @(negedge core_clk);
    check("bus off float", {14'h0000, hs_oe, ls_oe}, 16'h0000);
    wait_drv(1'b0);
    // no control word keeps the pins driven while the hardware enable is low
    @(posedge core_clk);
    hw_en <= 1'b0;
    wr(`PSC_OFS_CTRL, 16'hFFFF);
    wr(`PSC_OFS_CMD, 16'hFFFF);
    repeat (4) @(negedge core_clk);
    check("forced float", {14'h0000, hs_oe, ls_oe}, 16'h0000);
    // a pulse shorter than the enable delay never reaches the driver
    @(posedge core_clk);
    hw_en <= 1'b1;
    repeat (5) @(posedge core_clk);
    hw_en <= 1'b0;
    repeat (40) @(negedge core_clk);
    check("short pulse", {15'h0000, drv_en}, 16'h0000);
    final_report();
  end
endmodule : psc_gate_strap_tb_top
